// ===== shared/dod_pkg.sv
// Package of opcode patterns, operation codes and constants for the decoder
package dod_pkg;

   // ************************************************
   // Widths and reset values
   // ************************************************
   localparam int DOD_WORD_W = 16;
   localparam logic [3:0] DOD_SHIFT_RST = 4'h0;
   localparam logic [7:0] DOD_OPND_RST = 8'h00;
   localparam logic [3:0] DOD_NIB_RST = 4'h0;
   localparam logic [3:0] DOD_FIXED_SHIFT16 = 4'h0; // Shift 16 flagged apart
   localparam logic [2:0] DOD_CYC_ONE = 3'h1;
   localparam logic [2:0] DOD_CYC_TWO = 3'h2;
   localparam logic [2:0] DOD_CYC_FOUR = 3'h4;

   // ************************************************
   // Opcode patterns
   // ************************************************
   localparam logic [15:0] DOD_W_MAGNITUDE = 16'hbe00;
   localparam logic [15:0] DOD_W_PRODUCT_ACC = 16'hbe04;
   localparam logic [15:0] DOD_W_JUMP_ACC = 16'hbe20;
   localparam logic [15:0] DOD_W_AND_IMM16 = 16'hbe81;
   localparam logic [15:0] DOD_W_JUMP_PIN = 16'he000;
   localparam logic [15:0] DOD_W_JUMP_TSET = 16'he100;
   localparam logic [15:0] DOD_W_JUMP_TCLR = 16'he200;
   localparam logic [3:0] DOD_N_SUM_SHIFT = 4'h2;
   localparam logic [7:0] DOD_B_SUM_HIGH = 8'h61;
   localparam logic [7:0] DOD_B_SUM_SHORT = 8'hb8;
   localparam logic [7:0] DOD_B_SUM_CARRY = 8'h60;
   localparam logic [7:0] DOD_B_SUM_LOW = 8'h62;
   localparam logic [7:0] DOD_B_SUM_TEMP = 8'h63;
   localparam logic [7:0] DOD_B_AUX_INC = 8'h78;
   localparam logic [7:0] DOD_B_AND_MEM = 8'h6e;
   localparam logic [7:0] DOD_B_AUX_LOOP = 8'h7b;
   localparam logic [7:0] DOD_B_COND_JUMP = 8'he3;
   localparam logic [11:0] DOD_T_SUM_LONG = 12'hbf9;
   localparam logic [11:0] DOD_T_AND_LONG = 12'hbfb;

   // ************************************************
   // Flag-condition selector codes and condition bit positions
   // ************************************************
   localparam logic [1:0] DOD_SEL_PIN_LOW = 2'h0;
   localparam logic [1:0] DOD_SEL_TEST_SET = 2'h1;
   localparam logic [1:0] DOD_SEL_TEST_CLR = 2'h2;
   localparam logic [1:0] DOD_SEL_NONE = 2'h3;
   localparam int DOD_C_ZERO = 3;
   localparam int DOD_C_NEG = 2;
   localparam int DOD_C_OVF = 1;
   localparam int DOD_C_CARRY = 0;

   // ************************************************
   // Decoded operations
   // ************************************************
   typedef enum logic [4:0] {
      DOD_OP_NONE = 5'h00,
      DOD_OP_MAGNITUDE = 5'h01,
      DOD_OP_SUM_SHIFT = 5'h02,
      DOD_OP_SUM_HIGH = 5'h03,
      DOD_OP_SUM_SHORT = 5'h04,
      DOD_OP_SUM_LONG = 5'h05,
      DOD_OP_SUM_CARRY = 5'h06,
      DOD_OP_SUM_LOW = 5'h07,
      DOD_OP_SUM_TEMP = 5'h08,
      DOD_OP_AUX_INC = 5'h09,
      DOD_OP_AND_MEM = 5'h0a,
      DOD_OP_AND_LONG = 5'h0b,
      DOD_OP_AND_LONG16 = 5'h0c,
      DOD_OP_PRODUCT_ACC = 5'h0d,
      DOD_OP_JUMP_ACC = 5'h0e,
      DOD_OP_AUX_LOOP = 5'h0f,
      DOD_OP_JUMP_TSET = 5'h10,
      DOD_OP_JUMP_TCLR = 5'h11,
      DOD_OP_COND_JUMP = 5'h12,
      DOD_OP_JUMP_PIN = 5'h13
   } dod_op_t;

   typedef enum logic [0:0] {
      DOD_ST_OPCODE = 1'b0,
      DOD_ST_SECOND = 1'b1
   } dod_state_t;

endpackage

// ===== hdl/dod_cond_eval.sv
// Condition evaluator for flag selector and accumulator condition nibbles
`timescale 1ns/1ps
module dod_cond_eval
   import dod_pkg::*;
(
   // Condition fields
   input wire logic [1:0] flag_cond_select_i,
   input wire logic [3:0] state_nib_i,
   input wire logic [3:0] mask_nib_i,
   // Live status
   input wire logic test_flag_i,
   input wire logic branch_input_pin_i,
   input wire logic [3:0] acc_live_i,
   // Results
   output logic flag_met_o,
   output logic acc_met_o
);
   import dod_pkg::*;

   // ************************************************
   // Evaluation
   // ************************************************
   // Selector 11 tests nothing and so never passes on its own
   always_comb begin
      case (flag_cond_select_i)
         DOD_SEL_PIN_LOW: flag_met_o = ~branch_input_pin_i;
         DOD_SEL_TEST_SET: flag_met_o = test_flag_i;
         DOD_SEL_TEST_CLR: flag_met_o = ~test_flag_i;
         default: flag_met_o = 1'b0;
      endcase
   end

   // A masked bit is live when its condition matches the wanted state
   always_comb begin
      acc_met_o = |(mask_nib_i & ~(acc_live_i ^ state_nib_i));
   end
endmodule

// ===== hdl/dod_decoder.sv
// Opcode decoder with two-word consumption and condition evaluation
`timescale 1ns/1ps
// Contract
// - Selector 00 pin low, 01 test flag set, 10 clear, 11 none.
// - Condition nibble order: zero, negative, overflow, carry, MSB first.
// - Low four bits are a mask selecting conditions to test.
// - Bits 4 to 7 give required state of masked conditions.
// - Mask ANDed with live-equals-state match bits; any set bit means satisfied.
// - Word be00 is one-cycle magnitude of accumulator.
// - Nibble 0010 is shifted sum; shift bits 11-8, address low byte.
// - Prefix 61 sums high half; b8 sums short 8-bit immediate.
// - Prefix bf9 plus shift is two-word long-immediate shifted sum.
// - Prefixes 60, 62, 63: carry sum, unsigned low sum, temp-shift sum.
// - Prefix 78 sum_unsigned_low_op low-byte immediate to auxiliary register.
// - Prefix 6e ANDs data memory operand into accumulator.
// - Prefix bfb two-word AND with shift; be81 with shift sixteen.
// - Word be04 sum_unsigned_low_op product register to accumulator.
// - Word be20 jumps to accumulator address, four cycles.
// - Prefix 7b plus address word jumps when auxiliary nonzero.
// - Words e100, e200 plus address jump on test set, clear.
// - Prefix e3 sign jumps: 8/c nonneg, 4/4 neg, c/c nonpos.
// - Prefix e3 state 0 mask 4 jumps when the negative condition is clear.
// - Prefix e3: 1/1 carry, 0/1 no carry, 0/2 no overflow.
// - Word e000 plus address jumps when branch pin low.
module dod_decoder
   import dod_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Fetch side
   input wire logic word_valid_i,
   input wire logic [15:0] word_i,
   // Status from the datapath and pin
   input wire logic test_flag_i,
   input wire logic branch_input_pin_i,
   input wire logic acc_zero_i,
   input wire logic acc_neg_i,
   input wire logic acc_ovf_i,
   input wire logic acc_carry_i,
   input wire logic aux_nonzero_i,
   // Decoded outputs
   output logic dec_valid_o,
   output dod_pkg::dod_op_t op_o,
   output logic [3:0] shift_amount_field_o,
   output logic shift16_o,
   output logic [7:0] operand_o,
   output logic [15:0] long_word_o,
   output logic two_word_o,
   output logic [2:0] cycles_o,
   output logic [1:0] flag_cond_select_o,
   output logic [3:0] acc_cond_state_o,
   output logic [3:0] acc_cond_mask_o,
   output logic is_jump_o,
   output logic jump_taken_o,
   output logic illegal_o
);
   import dod_pkg::*;

   // ************************************************
   // State
   // ************************************************
   typedef struct packed {
      dod_state_t st;
      logic pin_m;
      logic pin_s;
      logic valid;
      dod_op_t op;
      logic [3:0] shift;
      logic shift16;
      logic [7:0] opnd;
      logic [15:0] lword;
      logic two;
      logic [2:0] cyc;
      logic [1:0] fsel;
      logic [3:0] snib;
      logic [3:0] mnib;
      logic jump;
      logic illegal;
   } dod_regs_t;

   dod_regs_t st_r;
   dod_regs_t st_nxt;

   // Condition results and the live accumulator conditions
   logic flag_met;
   logic acc_met;
   logic [3:0] acc_live;

   // Live conditions, zero in the top bit down to carry at the bottom
   assign acc_live = {acc_zero_i, acc_neg_i, acc_ovf_i, acc_carry_i};

   // ************************************************
   // Opcode classification
   // ************************************************
   // Patterns are exact words first, then twelve-, eight-, four-bit prefixes
   function automatic dod_op_t classify(input logic [15:0] w);
      dod_op_t r;
      r = DOD_OP_NONE;
      if (w == DOD_W_MAGNITUDE) r = DOD_OP_MAGNITUDE;
      else if (w == DOD_W_PRODUCT_ACC) r = DOD_OP_PRODUCT_ACC;
      else if (w == DOD_W_JUMP_ACC) r = DOD_OP_JUMP_ACC;
      else if (w == DOD_W_AND_IMM16) r = DOD_OP_AND_LONG16;
      else if (w == DOD_W_JUMP_PIN) r = DOD_OP_JUMP_PIN;
      else if (w == DOD_W_JUMP_TSET) r = DOD_OP_JUMP_TSET;
      else if (w == DOD_W_JUMP_TCLR) r = DOD_OP_JUMP_TCLR;
      else if (w[15:4] == DOD_T_SUM_LONG) r = DOD_OP_SUM_LONG;
      else if (w[15:4] == DOD_T_AND_LONG) r = DOD_OP_AND_LONG;
      else if (w[15:8] == DOD_B_SUM_HIGH) r = DOD_OP_SUM_HIGH;
      else if (w[15:8] == DOD_B_SUM_SHORT) r = DOD_OP_SUM_SHORT;
      else if (w[15:8] == DOD_B_SUM_CARRY) r = DOD_OP_SUM_CARRY;
      else if (w[15:8] == DOD_B_SUM_LOW) r = DOD_OP_SUM_LOW;
      else if (w[15:8] == DOD_B_SUM_TEMP) r = DOD_OP_SUM_TEMP;
      else if (w[15:8] == DOD_B_AUX_INC) r = DOD_OP_AUX_INC;
      else if (w[15:8] == DOD_B_AND_MEM) r = DOD_OP_AND_MEM;
      else if (w[15:8] == DOD_B_AUX_LOOP) r = DOD_OP_AUX_LOOP;
      else if (w[15:8] == DOD_B_COND_JUMP) r = DOD_OP_COND_JUMP;
      else if (w[15:12] == DOD_N_SUM_SHIFT) r = DOD_OP_SUM_SHIFT;
      return r;
   endfunction

   // Two-word forms carry a constant or a branch address behind the opcode
   function automatic logic needs_second(input dod_op_t o);
      case (o)
         DOD_OP_SUM_LONG, DOD_OP_AND_LONG, DOD_OP_AND_LONG16,
         DOD_OP_AUX_LOOP, DOD_OP_JUMP_TSET, DOD_OP_JUMP_TCLR,
         DOD_OP_COND_JUMP, DOD_OP_JUMP_PIN: needs_second = 1'b1;
         default: needs_second = 1'b0;
      endcase
   endfunction

   // ************************************************
   // Condition evaluation
   // ************************************************
   dod_cond_eval u_cond (
      .flag_cond_select_i(st_r.fsel),
      .state_nib_i(st_r.snib),
      .mask_nib_i(st_r.mnib),
      .test_flag_i(test_flag_i),
      .branch_input_pin_i(st_r.pin_s),
      .acc_live_i(acc_live),
      .flag_met_o(flag_met),
      .acc_met_o(acc_met)
   );

   // ************************************************
   // Next-state logic
   // ************************************************
   // Outputs update in one step so every field belongs to the same instruction
   always_comb begin
      st_nxt = st_r;
      st_nxt.pin_m = branch_input_pin_i;
      st_nxt.pin_s = st_r.pin_m;
      st_nxt.valid = 1'b0;
      case (st_r.st)
         DOD_ST_OPCODE: begin
            if (word_valid_i) begin
               st_nxt.op = classify(word_i);
               st_nxt.illegal = (classify(word_i) == DOD_OP_NONE);
               st_nxt.shift = word_i[11:8];
               st_nxt.shift16 = 1'b0;
               st_nxt.opnd = word_i[7:0];
               st_nxt.lword = 16'h0000;
               st_nxt.fsel = DOD_SEL_NONE;
               st_nxt.snib = word_i[7:4];
               st_nxt.mnib = word_i[3:0];
               st_nxt.jump = 1'b0;
               st_nxt.two = needs_second(classify(word_i));
               st_nxt.cyc = DOD_CYC_ONE;
               case (classify(word_i))
                  DOD_OP_SUM_LONG, DOD_OP_AND_LONG: begin
                     st_nxt.shift = word_i[3:0];
                     st_nxt.cyc = DOD_CYC_TWO;
                  end
                  DOD_OP_AND_LONG16: begin
                     st_nxt.shift = DOD_FIXED_SHIFT16;
                     st_nxt.shift16 = 1'b1;
                     st_nxt.cyc = DOD_CYC_TWO;
                  end
                  DOD_OP_JUMP_ACC: begin
                     st_nxt.jump = 1'b1;
                     st_nxt.cyc = DOD_CYC_FOUR;
                  end
                  DOD_OP_JUMP_PIN: st_nxt.fsel = DOD_SEL_PIN_LOW;
                  DOD_OP_JUMP_TSET: st_nxt.fsel = DOD_SEL_TEST_SET;
                  DOD_OP_JUMP_TCLR: st_nxt.fsel = DOD_SEL_TEST_CLR;
                  default: ;
               endcase
               if (needs_second(classify(word_i))) begin
                  st_nxt.st = DOD_ST_SECOND;
               end else begin
                  st_nxt.valid = 1'b1;
               end
            end
         end
         DOD_ST_SECOND: begin
            if (word_valid_i) begin
               // Second word is stored raw and never classified
               st_nxt.lword = word_i;
               st_nxt.valid = 1'b1;
               st_nxt.st = DOD_ST_OPCODE;
               if (st_r.op != DOD_OP_SUM_LONG && st_r.op != DOD_OP_AND_LONG &&
                   st_r.op != DOD_OP_AND_LONG16) begin
                  st_nxt.jump = 1'b1;
                  st_nxt.cyc = DOD_CYC_FOUR;
               end
            end
         end
         default: st_nxt.st = DOD_ST_OPCODE;
      endcase
      if (!resetn_i) begin
         st_nxt = '0;
         st_nxt.fsel = DOD_SEL_NONE;
      end
   end

   always_ff @(posedge clk_i) begin
      st_r <= st_nxt;
   end

   // ************************************************
   // Outputs
   // ************************************************
   // Taken is judged against live status, the pin after its two flops, in the cycle the decode is shown
   always_comb begin
      case (st_r.op)
         DOD_OP_JUMP_ACC: jump_taken_o = st_r.valid;
         DOD_OP_AUX_LOOP: jump_taken_o = st_r.valid & aux_nonzero_i;
         DOD_OP_JUMP_PIN, DOD_OP_JUMP_TSET, DOD_OP_JUMP_TCLR:
            jump_taken_o = st_r.valid & flag_met;
         DOD_OP_COND_JUMP:
            jump_taken_o = st_r.valid & acc_met;
         default: jump_taken_o = 1'b0;
      endcase
   end

   assign dec_valid_o = st_r.valid;
   assign op_o = st_r.op;
   assign shift_amount_field_o = st_r.shift;
   assign shift16_o = st_r.shift16;
   assign operand_o = st_r.opnd;
   assign long_word_o = st_r.lword;
   assign two_word_o = st_r.two;
   assign cycles_o = st_r.cyc;
   assign flag_cond_select_o = st_r.fsel;
   assign acc_cond_state_o = st_r.snib;
   assign acc_cond_mask_o = st_r.mnib;
   assign is_jump_o = st_r.jump;
   assign illegal_o = st_r.illegal & st_r.valid;

   // ************************************************
   // Checks
   // ************************************************
   property p_magnitude;
      @(posedge clk_i) disable iff (!resetn_i)
      (st_r.st == DOD_ST_OPCODE && word_valid_i && word_i == DOD_W_MAGNITUDE)
      |=> (dec_valid_o && op_o == DOD_OP_MAGNITUDE && cycles_o == 3'h1);
   endproperty
   a_magnitude: assert property (p_magnitude) else $error("magnitude");

   property p_sum_fields;
      @(posedge clk_i) disable iff (!resetn_i)
      (st_r.st == DOD_ST_OPCODE && word_valid_i && word_i[15:12] == 4'h2)
      |=> (op_o == DOD_OP_SUM_SHIFT && shift_amount_field_o == $past(word_i[11:8])
           && operand_o == $past(word_i[7:0]));
   endproperty
   a_sum_fields: assert property (p_sum_fields) else $error("sum fields");

   property p_second_raw;
      @(posedge clk_i) disable iff (!resetn_i)
      (st_r.st == DOD_ST_SECOND && word_valid_i) |=>
      (dec_valid_o && long_word_o == $past(word_i) && two_word_o);
   endproperty
   a_second_raw: assert property (p_second_raw) else $error("second word");

   property p_long_sum;
      @(posedge clk_i) disable iff (!resetn_i)
      (st_r.st == DOD_ST_OPCODE && word_valid_i && word_i[15:4] == 12'hbf9)
      |=> !dec_valid_o ##0 (st_r.st == DOD_ST_SECOND);
   endproperty
   a_long_sum: assert property (p_long_sum) else $error("long sum");

   property p_cond_eval;
      @(posedge clk_i) disable iff (!resetn_i)
      (dec_valid_o && op_o == DOD_OP_COND_JUMP) |->
      (jump_taken_o == |(acc_cond_mask_o & ~(acc_live ^ acc_cond_state_o)));
   endproperty
   a_cond_eval: assert property (p_cond_eval) else $error("cond eval");

   property p_pin_jump;
      @(posedge clk_i) disable iff (!resetn_i)
      (dec_valid_o && op_o == DOD_OP_JUMP_PIN) |->
      (jump_taken_o == !st_r.pin_s && flag_cond_select_o == 2'h0);
   endproperty
   a_pin_jump: assert property (p_pin_jump) else $error("pin jump");

   property p_tset_jump;
      @(posedge clk_i) disable iff (!resetn_i)
      (dec_valid_o && op_o == DOD_OP_JUMP_TSET) |-> (jump_taken_o == test_flag_i);
   endproperty
   a_tset_jump: assert property (p_tset_jump) else $error("test jump");

   property p_aux_loop;
      @(posedge clk_i) disable iff (!resetn_i)
      (dec_valid_o && op_o == DOD_OP_AUX_LOOP) |-> (jump_taken_o == aux_nonzero_i);
   endproperty
   a_aux_loop: assert property (p_aux_loop) else $error("aux loop");

   property p_jump_acc;
      @(posedge clk_i) disable iff (!resetn_i)
      (st_r.st == DOD_ST_OPCODE && word_valid_i && word_i == DOD_W_JUMP_ACC)
      |=> (cycles_o == 3'h4 && jump_taken_o && !two_word_o);
   endproperty
   a_jump_acc: assert property (p_jump_acc) else $error("acc jump");
endmodule

// ===== verification/dod_fetch_model.sv
// Behavioural model of the program fetch unit feeding the decoder
`timescale 1ns/1ps
module dod_fetch_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // Requests from the bench
   input wire logic req_i,
   input wire logic [15:0] req_word_i,
   // Fetch bus toward the decoder
   output logic word_valid_o,
   output logic [15:0] word_o
);
   // ************************************************
   // Fetch bus
   // ************************************************
   // Between fetches the bus toggles, so stale data never passes for a word
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         word_valid_o <= 1'b0;
         word_o <= 16'h0000;
      end else if (req_i) begin
         word_valid_o <= 1'b1;
         word_o <= req_word_i;
      end else begin
         word_valid_o <= 1'b0;
         word_o <= ~word_o;
      end
   end
endmodule

// ===== verification/dod_decoder_tb.sv
// Self-checking testbench for the opcode decoder
`timescale 1ns/1ps
module dod_decoder_tb;
   import dod_pkg::*;
   // ************************************************
   // Clock, reset and wiring
   // ************************************************
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic req = 1'b0;
   logic [15:0] req_word = 16'h0000;
   logic word_valid_i;
   logic [15:0] word_i;
   logic test_flag_i = 1'b0;
   logic branch_input_pin_i = 1'b1;
   logic [3:0] acc_live = 4'h0; // Zero, negative, overflow, carry
   logic aux_nonzero_i = 1'b0;
   logic dec_valid_o;
   dod_op_t op_o;
   logic [3:0] shift_o;
   logic shift16_o;
   logic [7:0] operand_o;
   logic [15:0] long_word_o;
   logic two_word_o;
   logic [2:0] cycles_o;
   logic [1:0] sel_o;
   logic [3:0] state_o;
   logic [3:0] mask_o;
   logic is_jump_o;
   logic jump_taken_o;
   logic illegal_o;
   int n_fail = 0;
   int cmp_count = 0;
   int tick = 0;

   // Clock toggles every half period of 2 ns
   always #2 clk_i = ~clk_i;

   dod_fetch_model fetch (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req),
      .req_word_i(req_word), .word_valid_o(word_valid_i), .word_o(word_i));

   dod_decoder uut (.clk_i(clk_i), .resetn_i(resetn_i),
      .word_valid_i(word_valid_i), .word_i(word_i),
      .test_flag_i(test_flag_i), .branch_input_pin_i(branch_input_pin_i),
      .acc_zero_i(acc_live[3]), .acc_neg_i(acc_live[2]),
      .acc_ovf_i(acc_live[1]), .acc_carry_i(acc_live[0]),
      .aux_nonzero_i(aux_nonzero_i), .dec_valid_o(dec_valid_o),
      .op_o(op_o), .shift_amount_field_o(shift_o), .shift16_o(shift16_o),
      .operand_o(operand_o), .long_word_o(long_word_o),
      .two_word_o(two_word_o), .cycles_o(cycles_o),
      .flag_cond_select_o(sel_o), .acc_cond_state_o(state_o),
      .acc_cond_mask_o(mask_o), .is_jump_o(is_jump_o),
      .jump_taken_o(jump_taken_o), .illegal_o(illegal_o));

   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic chk(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Status lines move at an edge; the pin gets time to cross its flops
   task automatic setc(input logic tf, input logic pin, input logic aux,
      input logic [3:0] live);
      @(posedge clk_i);
      test_flag_i <= tf;
      branch_input_pin_i <= pin;
      aux_nonzero_i <= aux;
      acc_live <= live;
   endtask

   task automatic send(input logic [15:0] w);
      @(posedge clk_i);
      req <= 1'b1;
      req_word <= w;
   endtask

   // Feeds one instruction, waits for its decode and checks common fields
   task automatic issue(input logic [15:0] w0, input logic [15:0] w1,
      input logic two, input dod_op_t op, input logic [2:0] cyc,
      input logic taken);
      int k;
      k = 0;
      send(w0);
      if (two) begin
         send(w1);
      end
      @(posedge clk_i);
      req <= 1'b0;
      #1;
      while (dec_valid_o !== 1'b1 && k < 8) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      chk("dec_valid", 16'(dec_valid_o), 16'h0001);
      chk("op", 16'(op_o), 16'(op));
      chk("illegal", 16'(illegal_o), 16'(op == DOD_OP_NONE));
      if (op != DOD_OP_NONE) begin
         chk("cycles", 16'(cycles_o), 16'(cyc));
      end
      chk("two_word", 16'(two_word_o), 16'(two));
      chk("long_word", long_word_o, two ? w1 : 16'h0000);
      chk("is_jump", 16'(is_jump_o), 16'(cyc == 3'h4));
      chk("taken", 16'(jump_taken_o), 16'(taken));
      @(posedge clk_i);
      #1;
      chk("no_second_decode", 16'(dec_valid_o), 16'h0000);
   endtask

   // ************************************************
   // Scenarios
   // ************************************************
   // Single-word operations, plus one word that matches nothing
   task automatic t_one();
      logic [15:0] w[12] = '{16'hbe00, 16'h2a5c, 16'h6133, 16'hb87f,
         16'h6044, 16'h6255, 16'h6366, 16'h7812, 16'h6e99, 16'hbe04,
         16'hbe20, 16'h5555};
      dod_op_t o[12] = '{DOD_OP_MAGNITUDE, DOD_OP_SUM_SHIFT,
         DOD_OP_SUM_HIGH, DOD_OP_SUM_SHORT, DOD_OP_SUM_CARRY,
         DOD_OP_SUM_LOW, DOD_OP_SUM_TEMP, DOD_OP_AUX_INC, DOD_OP_AND_MEM,
         DOD_OP_PRODUCT_ACC, DOD_OP_JUMP_ACC, DOD_OP_NONE};
      for (int i = 0; i < 12; i++) begin
         issue(w[i], 16'h0000, 1'b0, o[i], (i == 10) ? 3'h4 : 3'h1, i == 10);
         chk("operand", 16'(operand_o), 16'(w[i][7:0]));
      end
      issue(16'h2a5c, 16'h0000, 1'b0, DOD_OP_SUM_SHIFT, 3'h1, 1'b0);
      chk("shift", 16'(shift_o), 16'h000a);
      $display("Test one_word done");
   endtask

   // Two-word forms; second words be00 and e100 look like opcodes on purpose
   task automatic t_two();
      issue(16'hbf93, 16'hbe00, 1'b1, DOD_OP_SUM_LONG, 3'h2, 1'b0);
      chk("shift", 16'(shift_o), 16'h0003);
      issue(16'hbfb5, 16'h1234, 1'b1, DOD_OP_AND_LONG, 3'h2, 1'b0);
      chk("shift", 16'(shift_o), 16'h0005);
      chk("shift16", 16'(shift16_o), 16'h0000);
      issue(16'hbe81, 16'he100, 1'b1, DOD_OP_AND_LONG16, 3'h2, 1'b0);
      chk("shift16", 16'(shift16_o), 16'h0001);
      $display("Test two_word done");
   endtask

   // Flag, pin and auxiliary jumps with their selector codes
   task automatic t_flags();
      for (int i = 0; i < 2; i++) begin
         setc(i[0], i[0], i[0], 4'h0);
         issue(16'he100, 16'h0abc, 1'b1, DOD_OP_JUMP_TSET, 3'h4, i[0]);
         chk("select", 16'(sel_o), 16'h0001);
         issue(16'he200, 16'h0abd, 1'b1, DOD_OP_JUMP_TCLR, 3'h4, !i[0]);
         chk("select", 16'(sel_o), 16'h0002);
         issue(16'h7b40, 16'h0abe, 1'b1, DOD_OP_AUX_LOOP, 3'h4, i[0]);
         issue(16'he000, 16'h0abf, 1'b1, DOD_OP_JUMP_PIN, 3'h4, !i[0]);
         chk("select", 16'(sel_o), 16'h0000);
      end
      $display("Test flag_jumps done");
   endtask

   // Accumulator condition jumps against every live condition pattern
   task automatic t_cond();
      logic [7:0] sm[7] = '{8'h8c, 8'h44, 8'hcc, 8'h04, 8'h11, 8'h01,
         8'h02};
      logic exp;
      for (int j = 0; j < 7; j++) begin
         for (int v = 0; v < 16; v++) begin
            exp = |(sm[j][3:0] & ~(sm[j][7:4] ^ v[3:0]));
            setc(1'b0, 1'b1, 1'b0, v[3:0]);
            issue({8'he3, sm[j]}, 16'h0100, 1'b1, DOD_OP_COND_JUMP, 3'h4,
               exp);
            chk("state", 16'(state_o), 16'(sm[j][7:4]));
            chk("mask", 16'(mask_o), 16'(sm[j][3:0]));
         end
      end
      $display("Test cond_jumps done");
   endtask

   // ************************************************
   // Main sequence and hang guard
   // ************************************************
   // A generous ceiling: the whole run needs about 800 cycles
   always @(posedge clk_i) begin
      tick++;
      if (tick == 20000) begin
         n_fail++;
         $display("ERROR timeout expected %0d seen %0d", 0, tick);
         wrap_up();
      end
   end

   initial begin
      repeat (15) @(posedge clk_i);
      #1;
      chk("reset_select", 16'(sel_o), 16'h0003);
      chk("reset_op", 16'(op_o), 16'(DOD_OP_NONE));
      @(posedge clk_i);
      resetn_i <= 1'b1;
      t_one();
      t_two();
      t_flags();
      t_cond();
      wrap_up();
   end
endmodule
